// *** verilog/fast_timer_regs.vh ***
// register offsets, field positions, reset values for the fast timer block
// assumes a 32-bit axi4-lite slave with word-aligned registers
`ifndef FAST_TIMER_REGS_VH
`define FAST_TIMER_REGS_VH
`define OFS_COUNT 8'h00
`define OFS_CMP_A 8'h04
`define OFS_CMP_B 8'h08
`define OFS_TOP 8'h0c
`define OFS_CMP_D 8'h10
`define OFS_CTRL 8'h14
`define OFS_FLAGS 8'h18
`define OFS_DEAD 8'h1c
`define OFS_HIGH 8'h20
`define OFS_FORCE 8'h24
`define OFS_PLL 8'h28
`define TOP_RESET 10'h0ff
`define COUNT_MAX 10'h3ff
// control field positions
`define CTRL_CS_LSB 0
`define CTRL_WGM_BIT 4
`define CTRL_PWM_A 5
`define CTRL_PWM_B 6
`define CTRL_PWM_D 7
`define CTRL_COM_LSB 8
`define CTRL_DTPS_LSB 14
`define CTRL_IE_LSB 20
// flag positions
`define FLG_OVF 0
`define FLG_CMP_LSB 1
`define FLG_LOCK 4
`define PLL_TM_LSB 0
`endif

// *** verilog/fast_timer_compare_deadtime.v ***
// 10-bit up/down timer with three compare channels and dead-time pairs
// assumes axi4-lite master on core_clk; pll clock enters as a synchronous tick
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "fast_timer_regs.vh"

// Function
// - counter clears, increments or decrements per timer tick under mode control
// - bottom flags count zero; top flags count at its highest sequence value
// - timer tick comes from system clock or pll tick by source and postscale fields
// - clock source select zero stops the counter
// - software reads/writes count anytime; its write beats clear and count
// - equality signals match; match flag sets on the next timer tick
// - enabled set flag raises interrupt; cleared by service or writing one
// - pwm modes buffer compare writes until top or bottom; normal writes direct
// - reading a compare register returns the latest written, buffered value
// - force strobe in non-pwm updates waveform output only, no flag, no reload
// - count write blocks compare matches in the following timer tick
// - compare output action changes act immediately, never buffered
// - compare outputs keep value across waveform mode changes
// - dead time only in pwm with action 01; one generator per channel
// - dead-time prescaler divides timer tick by 1, 2, 4 or 8
// - edge loads 4-bit down counter with rising or falling nibble
// - rising edge of output or complement held until counter reaches zero
// - with zero dead time falling outputs lag waveform by one timer tick, rising ones by two
// - top compare resets to 0x0ff; counter maximum is 0x3ff
// - low-byte read copies upper bits to high buffer; write takes them back
module fast_timer_compare_deadtime #(
  parameter CW = 10
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // pll side
  input wire pll_tick,
  input wire pll_locked_flag,
  // interrupt service acknowledges, one per flag (ovf, a, b, d)
  input wire [3:0] irq_ack,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // outputs
  output reg [3:0] irq,
  output reg [2:0] compare_output_pin,
  output reg [2:0] compare_output_pin_n,
  output reg [2:0] waveform_output
);

  // ****************************************
  // register state
  // ****************************************
  reg [CW-1:0] timer_count_value_r;
  reg [CW-1:0] cmp_act_r [0:3];
  reg [CW-1:0] cmp_buf_r [0:3];
  reg [3:0] cmp_pend_r;
  reg [17:0] ctrl_r;
  reg [3:0] flags_r;
  reg [7:0] dead_time_values_r;
  reg [1:0] high_bits_buffer_r;
  reg [1:0] pll_timer_postscale_select_r;
  reg dir_down_r;
  reg block_r;
  reg [3:0] match_r;
  reg [2:0] tick_div_r;
  reg [2:0] dt_div_r;
  reg [3:0] irq_en_r;
  reg [2:0] force_r;
  reg [CW-1:0] rd_word;
  wire [1:0] rd_hi = rd_word[9:8];

  wire [3:0] clock_source_select = ctrl_r[`CTRL_CS_LSB+3:`CTRL_CS_LSB];
  wire waveform_mode_bit = ctrl_r[`CTRL_WGM_BIT];
  wire [2:0] pwm_enable_channel = ctrl_r[`CTRL_PWM_D:`CTRL_PWM_A];
  wire [5:0] compare_output_action = ctrl_r[`CTRL_COM_LSB+5:`CTRL_COM_LSB];
  wire [1:0] dead_time_prescale = ctrl_r[`CTRL_DTPS_LSB+1:`CTRL_DTPS_LSB];
  wire any_pwm = |pwm_enable_channel;
  wire [CW-1:0] top_v = cmp_act_r[2];

  // ****************************************
  // timer tick select and postscale
  // ****************************************
  reg timer_clock;
  wire pll_sel = pll_timer_postscale_select_r != 2'b00;
  wire src_tick = pll_sel ? pll_tick : 1'b1;
  always @* begin
    case (clock_source_select)
      4'h0: timer_clock = 1'b0;
      4'h1: timer_clock = src_tick;
      4'h2: timer_clock = src_tick & (tick_div_r[0] == 1'b1);
      4'h3: timer_clock = src_tick & (tick_div_r[1:0] == 2'b11);
      default: timer_clock = src_tick & (tick_div_r == 3'h7);
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      tick_div_r <= 3'h0;
    else if (src_tick)
      tick_div_r <= tick_div_r + 3'h1;
  end

  // ****************************************
  // axi4-lite handshake
  // ****************************************
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  wire wr_lo = wr_go & s_axi_wstrb[0];
  wire wr_hi = wr_go & s_axi_wstrb[1];
  wire [7:0] wa = s_axi_awaddr;
  wire wr_count = wr_lo & (wa == `OFS_COUNT);
  // low byte plus two bits from the shared high buffer
  wire [CW-1:0] wval = {high_bits_buffer_r, s_axi_wdata[7:0]};
  wire ra_ok = (s_axi_araddr <= `OFS_PLL) & (s_axi_araddr[1:0] == 2'b00);
  wire wa_ok = (wa <= `OFS_PLL) & (wa[1:0] == 2'b00);

  // ****************************************
  // counter
  // ****************************************
  wire bottom = timer_count_value_r == {CW{1'b0}};
  wire top = timer_count_value_r == top_v;
  wire at_max = timer_count_value_r == `COUNT_MAX;
  // phase correct pwm counts up and down; otherwise up then clear
  wire dual = any_pwm & waveform_mode_bit;
  reg [CW-1:0] cnt_nxt;
  reg down_nxt;
  reg ovf_evt;
  always @* begin
    cnt_nxt = timer_count_value_r;
    down_nxt = dir_down_r;
    ovf_evt = 1'b0;
    if (timer_clock) begin
      if (dual) begin
        if (!dir_down_r && (top || at_max)) begin
          down_nxt = 1'b1;
          cnt_nxt = timer_count_value_r - 1'b1;
        end else if (dir_down_r && bottom) begin
          down_nxt = 1'b0;
          cnt_nxt = timer_count_value_r + 1'b1;
          ovf_evt = 1'b1;
        end else if (dir_down_r)
          cnt_nxt = timer_count_value_r - 1'b1;
        else
          cnt_nxt = timer_count_value_r + 1'b1;
      end else begin
        down_nxt = 1'b0;
        if (top || at_max) begin
          cnt_nxt = {CW{1'b0}};
          ovf_evt = 1'b1;
        end else
          cnt_nxt = timer_count_value_r + 1'b1;
      end
    end
    if (wr_count)
      cnt_nxt = wval;
  end

  // update instant for buffered compares: top in single slope, bottom in dual
  wire upd = timer_clock & (dual ? (dir_down_r & bottom) : (top | at_max));

  // ****************************************
  // match, flags, buffers
  // ****************************************
  wire [3:0] eq;
  reg [3:0] cmp_wsel;
  always @* begin
    cmp_wsel = 4'h0;
    if (wr_lo) begin
      case (wa)
        `OFS_CMP_A: cmp_wsel = 4'h1;
        `OFS_CMP_B: cmp_wsel = 4'h2;
        `OFS_TOP: cmp_wsel = 4'h4;
        `OFS_CMP_D: cmp_wsel = 4'h8;
        default: cmp_wsel = 4'h0;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
      assign eq[gi] = timer_count_value_r == cmp_act_r[gi];
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cmp_act_r[gi] <= (gi == 2) ? `TOP_RESET : {CW{1'b0}};
          cmp_buf_r[gi] <= (gi == 2) ? `TOP_RESET : {CW{1'b0}};
          cmp_pend_r[gi] <= 1'b0;
        end else if (cmp_wsel[gi]) begin
          cmp_buf_r[gi] <= wval;
          if (any_pwm) begin
            cmp_pend_r[gi] <= 1'b1;
          end else begin
            cmp_act_r[gi] <= wval;
            cmp_pend_r[gi] <= 1'b0;
          end
        end else if (upd && cmp_pend_r[gi]) begin
          cmp_act_r[gi] <= cmp_buf_r[gi];
          cmp_pend_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // match captured per tick, flag set on the next tick; blocked after count write
  wire [3:0] hit = eq & {4{~block_r}};
  wire [3:0] set_f = {match_r[3], match_r[1:0], ovf_evt} & {4{timer_clock}};
  wire [3:0] clr_f = (wr_lo && wa == `OFS_FLAGS) ? s_axi_wdata[3:0] : 4'h0;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_count_value_r <= {CW{1'b0}};
      dir_down_r <= 1'b0;
      block_r <= 1'b0;
      match_r <= 4'h0;
      flags_r <= 4'h0;
      irq <= 4'h0;
    end else begin
      timer_count_value_r <= cnt_nxt;
      dir_down_r <= down_nxt;
      // held until one timer tick has passed after the write
      if (wr_count)
        block_r <= 1'b1;
      else if (timer_clock)
        block_r <= 1'b0;
      if (timer_clock)
        match_r <= hit;
      // set wins over clear
      flags_r <= (flags_r & ~clr_f & ~irq_ack) | set_f;
      irq <= flags_r & irq_en_r;
    end
  end

  // ****************************************
  // registers written by software
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 18'h0;
      dead_time_values_r <= 8'h00;
      high_bits_buffer_r <= 2'b00;
      pll_timer_postscale_select_r <= 2'b00;
      irq_en_r <= 4'h0;
      force_r <= 3'h0;
    end else begin
      force_r <= 3'h0;
      if (rd_go && s_axi_araddr <= `OFS_CMP_D && s_axi_araddr[1:0] == 2'b00)
        high_bits_buffer_r <= rd_hi;
      if (wr_lo) begin
        case (wa)
          `OFS_CTRL: ctrl_r[7:0] <= s_axi_wdata[7:0];
          `OFS_DEAD: dead_time_values_r <= s_axi_wdata[7:0];
          `OFS_HIGH: high_bits_buffer_r <= s_axi_wdata[1:0];
          `OFS_FORCE: force_r <= s_axi_wdata[2:0];
          `OFS_PLL: pll_timer_postscale_select_r <= s_axi_wdata[1:0];
          default: ;
        endcase
      end
      if (wr_hi && wa == `OFS_CTRL)
        ctrl_r[15:8] <= s_axi_wdata[15:8];
      if (wr_go && s_axi_wstrb[2] && wa == `OFS_CTRL) begin
        ctrl_r[17:16] <= s_axi_wdata[17:16];
        irq_en_r <= s_axi_wdata[23:20];
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  reg [31:0] rd_mux;
  always @* begin
    rd_word = {CW{1'b0}};
    case (s_axi_araddr)
      `OFS_COUNT: rd_word = timer_count_value_r;
      `OFS_CMP_A: rd_word = cmp_buf_r[0];
      `OFS_CMP_B: rd_word = cmp_buf_r[1];
      `OFS_TOP: rd_word = cmp_buf_r[2];
      `OFS_CMP_D: rd_word = cmp_buf_r[3];
      default: rd_word = {CW{1'b0}};
    endcase
    case (s_axi_araddr)
      `OFS_CTRL: rd_mux = {8'h00, irq_en_r, 2'b00, ctrl_r};
      `OFS_FLAGS: rd_mux = {27'h0, bottom, flags_r};
      `OFS_DEAD: rd_mux = {24'h0, dead_time_values_r};
      `OFS_HIGH: rd_mux = {30'h0, high_bits_buffer_r};
      `OFS_PLL: rd_mux = {29'h0, pll_locked_flag, pll_timer_postscale_select_r};
      default: rd_mux = {24'h0, rd_word[7:0]};
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ra_ok ? 2'b00 : 2'b10;
        s_axi_rdata <= ra_ok ? rd_mux : 32'h0;
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // waveform and dead time
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      dt_div_r <= 3'h0;
    else if (timer_clock)
      dt_div_r <= dt_div_r + 3'h1;
  end
  reg dt_tick;
  always @* begin
    case (dead_time_prescale)
      2'b00: dt_tick = timer_clock;
      2'b01: dt_tick = timer_clock & dt_div_r[0];
      2'b10: dt_tick = timer_clock & (dt_div_r[1:0] == 2'b11);
      default: dt_tick = timer_clock & (dt_div_r == 3'h7);
    endcase
  end

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ch
      localparam integer M = (gi == 2) ? 3 : gi;
      wire [1:0] act = compare_output_action[2*gi+1:2*gi];
      wire pwm = pwm_enable_channel[gi];
      wire hit_c = timer_clock & match_r[M];
      reg [3:0] dt_cnt_r;
      reg wprev_r;
      reg wv_nxt;
      always @* begin
        wv_nxt = waveform_output[gi];
        if (pwm) begin
          if (act != 2'b00 && hit_c)
            wv_nxt = 1'b0;
          if (act != 2'b00 && timer_clock && bottom && !dir_down_r)
            wv_nxt = 1'b1;
        end else if (hit_c || force_r[gi]) begin
          case (act)
            2'b01: wv_nxt = ~waveform_output[gi];
            2'b10: wv_nxt = 1'b0;
            2'b11: wv_nxt = 1'b1;
            default: wv_nxt = waveform_output[gi];
          endcase
        end
      end
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          waveform_output[gi] <= 1'b0;
          wprev_r <= 1'b0;
          dt_cnt_r <= 4'h0;
          compare_output_pin[gi] <= 1'b0;
          compare_output_pin_n[gi] <= 1'b0;
        end else begin
          waveform_output[gi] <= wv_nxt;
          if (timer_clock) begin
            wprev_r <= waveform_output[gi];
            if (pwm && act == 2'b01) begin
              if (waveform_output[gi] != wprev_r) begin
                // rising nibble on rise, falling nibble on fall
                dt_cnt_r <= waveform_output[gi] ? dead_time_values_r[7:4] : dead_time_values_r[3:0];
                compare_output_pin[gi] <= 1'b0;
                compare_output_pin_n[gi] <= 1'b0;
              end else if (dt_cnt_r != 4'h0) begin
                if (dt_tick)
                  dt_cnt_r <= dt_cnt_r - 4'h1;
              end else begin
                compare_output_pin[gi] <= wprev_r;
                compare_output_pin_n[gi] <= ~wprev_r;
              end
            end else begin
              dt_cnt_r <= 4'h0;
              compare_output_pin[gi] <= waveform_output[gi];
              compare_output_pin_n[gi] <= ~waveform_output[gi];
            end
          end
        end
      end
    end
  endgenerate

endmodule

// *** test/switch_driver_model.sv ***
// power switch pair driver model on the compare output pins
// assumes pins are sampled on core_clk; counts shoot-through and edges
`timescale 1ns/100ps
module switch_driver_model (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // gate drives per channel
  input wire [2:0] hi_side,
  input wire [2:0] lo_side,
  // observations
  output reg [15:0] n_overlap,
  output reg [15:0] n_edges
);
  // ************
  // gate watch
  // ************
  reg [2:0] hi_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      n_overlap <= 16'h0000;
      n_edges <= 16'h0000;
      hi_q <= 3'h0;
    end else begin
      // both switches of one leg on is a short
      if ((hi_side & lo_side) != 3'h0) n_overlap <= n_overlap + 16'h0001;
      if (hi_side != hi_q) n_edges <= n_edges + 16'h0001;
      hi_q <= hi_side;
    end
  end
endmodule

// *** test/fast_timer_chk.sv ***
// concurrent checks on the fast timer top ports
// assumes bind onto the design top, single core_clk domain
`timescale 1ns/100ps
module fast_timer_chk #(
  parameter CW = 10
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // bus
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // outputs
  input wire [2:0] compare_output_pin,
  input wire [2:0] compare_output_pin_n,
  input wire [2:0] waveform_output
);
  // ************
  // properties
  // ************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence rd_take;
    s_axi_arvalid && !s_axi_rvalid;
  endsequence
  chk_write_answer: assert property (wr_take |=> s_axi_bvalid)
    else $error("write response late");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read response late");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("second write taken");
  chk_bad_addr: assert property (wr_take ##0 (s_axi_awaddr > 8'h28) |=> s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  chk_pair_no_overlap: assert property ((compare_output_pin & compare_output_pin_n) == 3'h0)
    else $error("output pair overlaps");
  chk_pin_lags_wave: assert property ($rose(compare_output_pin[0]) |-> $past(waveform_output[0]))
    else $error("pin rose ahead of waveform");
endmodule
bind fast_timer_compare_deadtime fast_timer_chk #(.CW(CW)) u_chk (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .compare_output_pin(compare_output_pin),
  .compare_output_pin_n(compare_output_pin_n),
  .waveform_output(waveform_output)
);

// *** test/fast_timer_compare_deadtime_tb_top.sv ***
// self-checking bench for the fast timer block
// assumes the switch driver model and the bound checker are compiled first
`timescale 1ns/100ps
`include "fast_timer_regs.vh"
module fast_timer_compare_deadtime_tb_top;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg pll_tick = 1'b0;
  reg pll_locked_flag = 1'b0;
  reg [3:0] irq_ack = 4'h0;
  reg [7:0] awaddr = 8'h00;
  reg awvalid = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg [7:0] araddr = 8'h00;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] irq;
  wire [2:0] pin, pin_n, wave;
  wire [15:0] n_overlap, n_edges;
  integer n_fail = 0;
  integer tests_run = 0;
  integer seed = 32'h35ad;
  integer i;
  reg [1:0] resp;
  reg [31:0] rd_q, v;
  reg w1;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) pll_tick <= ^$random(seed);
  initial #120000 pll_locked_flag = 1'b1;
  fast_timer_compare_deadtime u_dut (.core_clk(core_clk), .rst_n(rst_n), .pll_tick(pll_tick),
    .pll_locked_flag(pll_locked_flag), .irq_ack(irq_ack), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
    .compare_output_pin(pin), .compare_output_pin_n(pin_n), .waveform_output(wave));
  switch_driver_model u_sw (.core_clk(core_clk), .rst_n(rst_n), .hi_side(pin), .lo_side(pin_n),
    .n_overlap(n_overlap), .n_edges(n_edges));
  // ************
  // helpers
  // ************
  function [31:0] ctrl(input [3:0] cs, input [2:0] pwm, input [5:0] com, input [1:0] dtps, input [3:0] ie);
    ctrl = (cs << `CTRL_CS_LSB) | (pwm << `CTRL_PWM_A) | (com << `CTRL_COM_LSB) | (dtps << `CTRL_DTPS_LSB) |
      (ie << `CTRL_IE_LSB);
  endfunction
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      @(posedge core_clk);
      while (awready !== 1'b1) @(posedge core_clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      @(posedge core_clk);
      while (bvalid !== 1'b1) @(posedge core_clk);
      bready <= 1'b1;
      @(posedge core_clk);
      resp = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      @(posedge core_clk);
      while (arready !== 1'b1) @(posedge core_clk);
      arvalid <= 1'b0;
      @(posedge core_clk);
      while (rvalid !== 1'b1) @(posedge core_clk);
      rready <= 1'b1;
      @(posedge core_clk);
      rd_q = rdata;
      resp = rresp;
      rready <= 1'b0;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #400000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
  // ************
  // scenarios
  // ************
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`OFS_TOP);
    chk(rd_q[7:0], 8'hff);
    rd(`OFS_HIGH);
    chk(rd_q[1:0], 2'h0);
    wr(`OFS_HIGH, 32'h2);
    wr(`OFS_CMP_A, 32'h34);
    wr(`OFS_HIGH, 32'h0);
    rd(`OFS_CMP_A);
    chk(rd_q[7:0], 8'h34);
    rd(`OFS_HIGH);
    chk(rd_q[1:0], 2'h2);
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      v[3:0] = 4'h5; // keeps the count clear of every compare value
      wr(`OFS_HIGH, v[9:8]);
      wr(`OFS_COUNT, v[7:0]);
      repeat (5) @(posedge core_clk);
      rd(`OFS_COUNT);
      chk(rd_q[7:0], v[7:0]);
      rd(`OFS_HIGH);
      chk(rd_q[1:0], v[9:8]);
    end
    wr(`OFS_HIGH, 32'h0);
    wr(`OFS_CMP_A, 32'h10);
    wr(`OFS_COUNT, 32'h10); // compare equal on purpose, match must be blocked
    wr(`OFS_FLAGS, 32'hf);
    wr(`OFS_CTRL, ctrl(4'h1, 3'h0, 6'h00, 2'h0, 4'h0));
    repeat (20) @(posedge core_clk);
    rd(`OFS_FLAGS);
    chk(rd_q[1], 1'b0);
    repeat (300) @(posedge core_clk);
    rd(`OFS_FLAGS);
    chk(rd_q[1:0], 2'h3);
    chk(irq, 4'h0);
    wr(`OFS_CTRL, ctrl(4'h1, 3'h0, 6'h00, 2'h0, 4'h2));
    repeat (2) @(posedge core_clk);
    chk(irq[1], 1'b1);
    irq_ack <= 4'h2;
    @(posedge core_clk);
    irq_ack <= 4'h0;
    repeat (3) @(posedge core_clk);
    chk(irq[1], 1'b0);
    wr(`OFS_FLAGS, 32'h1);
    rd(`OFS_FLAGS);
    chk(rd_q[0], 1'b0);
    // stopped timer, force the waveform before pins matter
    wr(`OFS_CTRL, ctrl(4'h0, 3'h0, 6'h03, 2'h0, 4'h0));
    wr(`OFS_FLAGS, 32'hf);
    wr(`OFS_FORCE, 32'h1);
    rd(`OFS_FLAGS);
    chk(rd_q[3:1], 3'h0);
    w1 = wave[0];
    wr(`OFS_CTRL, ctrl(4'h0, 3'h0, 6'h02, 2'h0, 4'h0));
    wr(`OFS_FORCE, 32'h1);
    chk(wave[0], !w1);
    wr(`OFS_CTRL, ctrl(4'h0, 3'h1, 6'h00, 2'h0, 4'h0));
    wr(`OFS_CMP_A, 32'h5a);
    rd(`OFS_CMP_A);
    chk(rd_q[7:0], 8'h5a);
    wr(`OFS_CMP_A, 32'h40);
    wr(`OFS_DEAD, 32'h32);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`OFS_CTRL, ctrl(4'h1, 3'h1, 6'h01, i[1:0], 4'h0));
      repeat (600) @(posedge core_clk);
    end
    chk(n_overlap, 16'h0);
    chk(n_edges != 16'h0, 1'b1);
    rd(8'h2c);
    chk(resp, 2'h2);
    wr(8'h30, 32'h0);
    chk(resp, 2'h2);
    // pll start-up: settle wait, poll lock, then postscale
    wr(`OFS_CTRL, ctrl(4'h0, 3'h0, 6'h00, 2'h0, 4'h0));
    repeat (10000) @(posedge core_clk);
    rd(`OFS_PLL);
    while (rd_q[2] !== 1'b1) rd(`OFS_PLL);
    wr(`OFS_PLL, 32'h1 << `PLL_TM_LSB);
    wr(`OFS_CTRL, ctrl(4'h1, 3'h0, 6'h00, 2'h0, 4'h0));
    rd(`OFS_COUNT);
    v = rd_q;
    repeat (20) @(posedge core_clk);
    rd(`OFS_COUNT);
    chk(rd_q[7:0] != v[7:0], 1'b1);
    report_and_stop;
  end
endmodule
